// [hdl/rcem_regs.sv]
// receiver comparator / envelope / shut-off register bank with APB slave
// How it works
// RULE1: reference tracks with nr over filter clock
// RULE2: tracking code selects nr 128..1365.3
// RULE3: filter corner code 631/659/689/712 kHz
// RULE4: host programs trim bits for detection type
// RULE5: discharge code selects tr, ASK with QC2
// RULE6: charge code selects tp, ASK with QC2
// RULE7: timeout 2^15 periods times n-1, zero 255
// RULE8: timeout without detection enters battery saving
// RULE9: new duration loads only entering run
// RULE10: nonvolatile load mode locks duration at reset
// RULE11: status bit 7 shows PLL lock
// RULE12: bits 6..4 mirror detection outputs
// RULE13: status bits 3..0 read zero
// RULE14: envelope monitor, zero in FSK
// RULE15: drift monitor saturates, zero when disabled
// RULE16: average monitor, zero when disabled
// RULE17: monitor reads harmless, writes ignored
`timescale 1ns/1ns
`include "rcem_defines.svh"
module rcem_regs
  import rcem_pkg::*;
#(
  parameter int SHUTOFF_UNIT = `RCEM_SHUTOFF_UNIT  // ref periods per duration step
) (
  input  wire logic        pclk,            // apb clock, 125 MHz
  input  wire logic        presetn,         // async reset, active low
  input  wire logic        clk_en,          // freezes all state when low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb write
  input  wire logic [11:0] paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error
  input  wire logic        ref_tick,        // reference clock period pulse
  input  wire logic        wake_req,        // leave saving/standby for run
  input  wire logic        nvm_mode,        // config from nonvolatile memory
  input  wire logic        digital_en,      // digital block enabled
  input  wire rcem_detect_t det_pins,       // lock and detection, async
  input  wire logic [7:0]  envelope_in,     // envelope_level_value source
  input  wire logic [8:0]  drift_in,        // reference_drift_value, 9 bit
  input  wire logic [7:0]  average_in,      // reference_average_value
  input  wire logic        qc1_settled,     // quick charge 1 settling done
  input  wire logic        qc2_below_th,    // |vref-vi| below threshold
  output rcem_cmp_cfg_t    cmp_cfg,         // comparator settings
  output rcem_env_cfg_t    env_cfg,         // envelope settings
  output logic [12:0]      track_nr_x3,     // 3 x nr for tracking
  output logic             track_active,    // nr tracking in force
  output logic [9:0]       corner_khz,      // filter corner in kHz
  output logic [11:0]      tr_x3,           // 3 x tr
  output logic [6:0]       tp_val,          // tp
  output logic             env_coef_valid,  // envelope fields in force
  output logic             batt_save,       // battery saving request
  output logic             irq              // level interrupt
);

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  rcem_detect_t det_s1_q, det_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_s1_q <= '0;
      det_s2_q <= '0;
    end else if (clk_en) begin
      det_s1_q <= det_pins;
      det_s2_q <= det_s1_q;
    end
  end

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  function automatic logic [7:0] idx_of(input logic [11:0] a);
    idx_of = a[9:2];
  endfunction : idx_of

  logic       wr_en;
  logic [7:0] widx;
  logic [7:0] wbyte;
  logic       mapped;
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite & clk_en;
  assign widx   = idx_of(paddr);
  assign wbyte  = pwdata[7:0];
  always_comb begin
    mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
             ((widx >= `RCEM_IDX_CMP_SET && widx <= `RCEM_IDX_AVG_MON) ||
              (widx >= `RCEM_IDX_CTRL && widx <= `RCEM_IDX_IRQ_MASK));
  end
  assign pslverr = psel & penable & ~mapped;

  // --------------------------------------------------------------
  // writable registers
  // --------------------------------------------------------------
  logic [7:0] cmp_set_q, env_set_q, shutoff_q, ctrl_q, irq_mask_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_set_q  <= `RCEM_RST_CMP_SET;
      env_set_q  <= `RCEM_RST_ENV_SET;
      shutoff_q  <= `RCEM_RST_SHUTOFF;
      ctrl_q     <= `RCEM_RST_CTRL;
      irq_mask_q <= 8'h00;
    end else if (clk_en) begin
      if (nvm_mode) begin
        shutoff_q <= `RCEM_RST_SHUTOFF;           // [RULE10]
      end else if (wr_en && widx == `RCEM_IDX_SHUTOFF) begin
        shutoff_q <= wbyte;
      end
      if (wr_en) begin
        unique case (widx)
          `RCEM_IDX_CMP_SET:  cmp_set_q  <= wbyte;
          `RCEM_IDX_ENV_SET:  env_set_q  <= wbyte;
          `RCEM_IDX_CTRL:     ctrl_q     <= {4'h0, wbyte[3:0]};
          `RCEM_IDX_IRQ_MASK: irq_mask_q <= {5'h00, wbyte[2:0]};
          default: ;                               // read-only ignored [RULE17]
        endcase
      end
    end
  end

  logic shutoff_b_en, qc2_en, ask_mode;
  assign shutoff_b_en = ctrl_q[`RCEM_CTL_SHUTOFF_B];
  assign qc2_en       = ctrl_q[`RCEM_CTL_QC2_EN];
  assign ask_mode     = ctrl_q[`RCEM_CTL_ASK];
  assign cmp_cfg      = rcem_cmp_cfg_t'(cmp_set_q[5:0]);
  assign env_cfg      = rcem_env_cfg_t'(env_set_q);

  // --------------------------------------------------------------
  // coefficient decode (3 x value keeps thirds exact)
  // --------------------------------------------------------------
  function automatic logic [12:0] x3_of(input logic [2:0] c, input logic [12:0] base);
    logic [12:0] even;
    even = base << c[2:1];
    x3_of = c[0] ? 13'(even * 13'd4) : 13'(even * 13'd3);
  endfunction : x3_of

  always_comb begin
    track_nr_x3    = x3_of(cmp_cfg.track_coef, 13'd128);             // [RULE2]
    tr_x3          = 12'(x3_of(env_cfg.discharge, 13'd64));          // [RULE5]
    tp_val         = 7'(7'd8 << env_cfg.charge);                    // [RULE6]
    env_coef_valid = ask_mode & qc2_en;                              // [RULE5] [RULE6]
    track_active   = ~qc2_en | qc1_settled | qc2_below_th;          // [RULE1]
    unique case (cmp_cfg.filt_freq)                                  // [RULE3]
      2'b00: corner_khz = 10'd631;
      2'b01: corner_khz = 10'd659;
      2'b10: corner_khz = 10'd689;
      2'b11: corner_khz = 10'd712;
    endcase
  end

  // --------------------------------------------------------------
  // shut-off timer
  // --------------------------------------------------------------
  rcem_run_state_t st_q;
  logic [7:0]  dur_q;
  logic [7:0]  units_q;
  logic [15:0] sub_q;
  logic        detected, timeout;
  assign detected = det_s2_q.strength | det_s2_q.noise | det_s2_q.preamble;
  assign timeout  = (units_q == 8'h00);  // whole units used up, n=1 at once

  // duration latched only entering run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= RCEM_ST_SAVE;
      dur_q   <= 8'h00;
      units_q <= 8'h00;
      sub_q   <= 16'h0000;
    end else if (clk_en) begin
      unique case (st_q)
        RCEM_ST_SAVE: begin
          if (wake_req) begin
            st_q    <= RCEM_ST_RUN;
            dur_q   <= shutoff_q;                                    // [RULE9]
            units_q <= (shutoff_q == 8'h00) ? `RCEM_SHUTOFF_ZERO_N   // [RULE7]
                                            : 8'(shutoff_q - 8'h01);
            sub_q   <= 16'(SHUTOFF_UNIT - 1);
          end
        end
        // saving held until run is dropped; next rise reloads the duration
        RCEM_ST_OFF: begin
          if (!wake_req) begin
            st_q <= RCEM_ST_SAVE;
          end
        end
        RCEM_ST_RUN: begin
          if (!wake_req) begin
            st_q <= RCEM_ST_SAVE;
          end else if (shutoff_b_en && !detected) begin
            if (timeout) begin
              st_q <= RCEM_ST_OFF;                                   // [RULE8]
            end else if (ref_tick) begin
              if (sub_q == 16'h0000) begin
                units_q <= units_q - 8'h01;
                sub_q   <= 16'(SHUTOFF_UNIT - 1);
              end else begin
                sub_q <= sub_q - 16'h0001;
              end
            end
          end
        end
        default: st_q <= RCEM_ST_SAVE;
      endcase
    end
  end
  assign batt_save = (st_q == RCEM_ST_OFF);

  // --------------------------------------------------------------
  // monitors and interrupts
  // --------------------------------------------------------------
  logic [7:0] status_v, env_v, drift_v, avg_v;
  always_comb begin
    status_v = {det_s2_q.lock, det_s2_q.strength,                    // [RULE11] [RULE12]
                det_s2_q.noise, det_s2_q.preamble, 4'h0};           // [RULE13]
    env_v    = ask_mode ? envelope_in : 8'h00;                       // [RULE14]
    drift_v  = !digital_en ? 8'h00 :                                 // [RULE15]
               (drift_in[8] ? `RCEM_DRIFT_SAT : drift_in[7:0]);
    avg_v    = digital_en ? average_in : 8'h00;                      // [RULE16]
  end

  logic [2:0] irq_stat_q;
  logic       lock_d1_q, det_d1_q, off_d1_q;
  logic [2:0] ev;
  assign ev = {detected & ~det_d1_q, ~det_s2_q.lock & lock_d1_q, batt_save & ~off_d1_q};
  // events set, write one clears; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h0;
      lock_d1_q  <= 1'b0;
      det_d1_q   <= 1'b0;
      off_d1_q   <= 1'b0;
    end else if (clk_en) begin
      lock_d1_q  <= det_s2_q.lock;
      det_d1_q   <= detected;
      off_d1_q   <= batt_save;
      irq_stat_q <= (irq_stat_q & ~((wr_en && widx == `RCEM_IDX_IRQ_STAT) ?
                    wbyte[2:0] : 3'h0)) | ev;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q[2:0]);

  // read mux; reads have no side effects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      unique case (widx)                                             // [RULE17]
        `RCEM_IDX_CMP_SET:   prdata <= {24'h0, cmp_set_q};
        `RCEM_IDX_ENV_SET:   prdata <= {24'h0, env_set_q};
        `RCEM_IDX_SHUTOFF:   prdata <= {24'h0, shutoff_q};
        `RCEM_IDX_STATUS:    prdata <= {24'h0, status_v};
        `RCEM_IDX_ENV_MON:   prdata <= {24'h0, env_v};
        `RCEM_IDX_DRIFT_MON: prdata <= {24'h0, drift_v};
        `RCEM_IDX_AVG_MON:   prdata <= {24'h0, avg_v};
        `RCEM_IDX_CTRL:      prdata <= {24'h0, ctrl_q};
        `RCEM_IDX_IRQ_STAT:  prdata <= {29'h0, irq_stat_q};
        `RCEM_IDX_IRQ_MASK:  prdata <= {24'h0, irq_mask_q};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  property p_nvm_lock;
    @(posedge pclk) disable iff (!presetn)
      (nvm_mode && clk_en) |=> (shutoff_q == `RCEM_RST_SHUTOFF);
  endproperty
  a_nvm_lock: assert property (p_nvm_lock) else $error("duration changed in nvm mode"); // [RULE10]

  property p_dur_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_q == RCEM_ST_RUN && $past(st_q) == RCEM_ST_RUN) |-> $stable(dur_q);
  endproperty
  a_dur_hold: assert property (p_dur_hold) else $error("duration changed while running"); // [RULE9]

  property p_status_low;
    @(posedge pclk) disable iff (!presetn) status_v[3:0] == 4'h0;
  endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits nonzero"); // [RULE13]

  property p_lock;
    @(posedge pclk) disable iff (!presetn) clk_en[*2] |-> status_v[7] == $past(det_s1_q.lock);
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit mismatch"); // [RULE11]

  property p_fsk_env;
    @(posedge pclk) disable iff (!presetn) !ask_mode |-> env_v == 8'h00;
  endproperty
  a_fsk_env: assert property (p_fsk_env) else $error("envelope nonzero in fsk"); // [RULE14]

  property p_drift_sat;
    @(posedge pclk) disable iff (!presetn)
      (digital_en && drift_in[8]) |-> drift_v == 8'hFF;
  endproperty
  a_drift_sat: assert property (p_drift_sat) else $error("drift not saturated"); // [RULE15]

  property p_avg_off;
    @(posedge pclk) disable iff (!presetn) !digital_en |-> avg_v == 8'h00;
  endproperty
  a_avg_off: assert property (p_avg_off) else $error("average nonzero when disabled"); // [RULE16]

  sequence s_enter_run;
    clk_en && st_q != RCEM_ST_RUN && wake_req;
  endsequence
  property p_units_load;
    @(posedge pclk) disable iff (!presetn)
      s_enter_run ##1 (st_q == RCEM_ST_RUN) |->
        units_q == ((dur_q == 8'h00) ? 8'hFF : 8'(dur_q - 8'h01));
  endproperty
  a_units_load: assert property (p_units_load) else $error("timeout count wrong"); // [RULE7]

  property p_off;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && st_q == RCEM_ST_RUN && wake_req && shutoff_b_en && !detected && timeout)
        |=> batt_save;
  endproperty
  a_off: assert property (p_off) else $error("no battery saving on timeout"); // [RULE8]

  property p_ro_ignored;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && !nvm_mode && widx >= `RCEM_IDX_STATUS && widx <= `RCEM_IDX_AVG_MON)
        |=> $stable({cmp_set_q, env_set_q, shutoff_q, ctrl_q, irq_mask_q});
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("ro write landed"); // [RULE17]

  property p_cmp_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && widx == `RCEM_IDX_CMP_SET) |=> cmp_set_q == $past(wbyte);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("cmp write lost"); // [RULE2]

  property p_dur_load;
    @(posedge pclk) disable iff (!presetn)
      s_enter_run ##1 (st_q == RCEM_ST_RUN) |-> dur_q == $past(shutoff_q);
  endproperty
  a_dur_load: assert property (p_dur_load) else $error("duration not latched"); // [RULE9]

  property p_unit_one;
    @(posedge pclk) disable iff (!presetn)
      s_enter_run ##1 (clk_en && st_q == RCEM_ST_RUN && dur_q == 8'h01 && wake_req &&
                       shutoff_b_en && !detected) |=> batt_save;
  endproperty
  a_unit_one: assert property (p_unit_one) else $error("n=1 not immediate"); // [RULE7]

  property p_off_hold;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && batt_save && wake_req) |=> batt_save;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("saving left early"); // [RULE8]

  property p_detect_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_q == RCEM_ST_RUN && detected) |=> !batt_save;
  endproperty
  a_detect_hold: assert property (p_detect_hold) else $error("off despite detect"); // [RULE8]

  property p_b_off;
    @(posedge pclk) disable iff (!presetn)
      (st_q == RCEM_ST_RUN && !shutoff_b_en) |=> !batt_save;
  endproperty
  a_b_off: assert property (p_b_off) else $error("off with type b disabled"); // [RULE8]

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && !penable && !pwrite && widx == `RCEM_IDX_STATUS)
        |=> prdata[7:0] == $past(status_v);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // [RULE11]

  property p_irq_set;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && batt_save && !off_d1_q) |=> irq_stat_q[`RCEM_IRQ_SHUTOFF];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("shutoff event lost"); // [RULE8]

endmodule : rcem_regs

// [hdl/rcem_defines.svh]
// register offsets, field positions, reset values and timing counts
`ifndef RCEM_DEFINES_SVH
`define RCEM_DEFINES_SVH
// printed offsets are not all multiples of four: index, byte address = 4 x index
`define RCEM_IDX_CMP_SET      8'h1B
`define RCEM_IDX_ENV_SET      8'h1C
`define RCEM_IDX_SHUTOFF      8'h1D
`define RCEM_IDX_STATUS       8'h1E
`define RCEM_IDX_ENV_MON      8'h1F
`define RCEM_IDX_DRIFT_MON    8'h20
`define RCEM_IDX_AVG_MON      8'h21
`define RCEM_IDX_CTRL         8'h30
`define RCEM_IDX_IRQ_STAT     8'h31
`define RCEM_IDX_IRQ_MASK     8'h32
`define RCEM_RST_CMP_SET      8'h60
`define RCEM_RST_ENV_SET      8'h88
`define RCEM_RST_SHUTOFF      8'h00
`define RCEM_RST_CTRL         8'h00
// status register bit positions
`define RCEM_ST_LOCK          7
`define RCEM_ST_STRENGTH      6
`define RCEM_ST_NOISE         5
`define RCEM_ST_PREAMBLE      4
// control register bit positions
`define RCEM_CTL_SHUTOFF_B    0
`define RCEM_CTL_QC2_EN       1
`define RCEM_CTL_ASK          2
`define RCEM_CTL_NIR_EN       3
// interrupt bit positions
`define RCEM_IRQ_SHUTOFF      0
`define RCEM_IRQ_LOCK_LOSS    1
`define RCEM_IRQ_DETECT       2
// shut-off unit: 2^15 reference periods; zero code means 255 units
`define RCEM_SHUTOFF_UNIT     32768
`define RCEM_SHUTOFF_ZERO_N   8'hFF
// drift saturation: 165.75 kHz at 0.65 kHz/LSB is the 8-bit full scale, 255
`define RCEM_DRIFT_SAT        8'hFF
`endif

// [hdl/rcem_pkg.sv]
// types shared by the register bank
package rcem_pkg;
  typedef enum logic [1:0] {
    RCEM_ST_SAVE = 2'b00,
    RCEM_ST_RUN  = 2'b01,
    RCEM_ST_OFF  = 2'b10
  } rcem_run_state_t;
  typedef struct packed {
    logic [2:0] track_coef;    // comparator_track_coef
    logic [1:0] filt_freq;     // interference_filter_freq
    logic       trim_a;        // filter_trim_a
  } rcem_cmp_cfg_t;
  typedef struct packed {
    logic [2:0] discharge;     // envelope_discharge_coef
    logic [1:0] charge;        // envelope_charge_coef
    logic       trim_b;
    logic       trim_c;
    logic       trim_d;
  } rcem_env_cfg_t;
  typedef struct packed {
    logic       lock;
    logic       strength;
    logic       noise;
    logic       preamble;
  } rcem_detect_t;
endpackage : rcem_pkg

// [testbench/rcem_regs_tb.sv]
// self-checking bench for the receiver comparator and envelope register bank
`timescale 1ns/1ns
`include "rcem_defines.svh"
module rcem_regs_tb;
  import rcem_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic          pclk, presetn, psel, penable, pwrite, ref_tick, wake_req, nvm_mode;
  logic          digital_en, qc1_settled, qc2_below_th, pready, pslverr, batt_save;
  logic          irq, env_coef_valid, track_active, err, irq_a, clk_en;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rdat;
  logic [7:0]    envelope_in, average_in, v;
  logic [8:0]    drift_in;
  logic [12:0]   track_nr_x3;
  logic [9:0]    corner_khz;
  logic [11:0]   tr_x3;
  logic [6:0]    tp_val;
  rcem_detect_t  det_pins;
  rcem_cmp_cfg_t cmp_cfg;
  rcem_env_cfg_t env_cfg;
  int            mismatches, cmp_count, cyc, t0;

  // unit under test, shortened shut-off unit
  rcem_regs #(.SHUTOFF_UNIT(4)) rcem_regs_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_tick(ref_tick), .wake_req(wake_req), .nvm_mode(nvm_mode),
    .digital_en(digital_en), .det_pins(det_pins), .envelope_in(envelope_in),
    .drift_in(drift_in), .average_in(average_in), .qc1_settled(qc1_settled),
    .qc2_below_th(qc2_below_th), .cmp_cfg(cmp_cfg), .env_cfg(env_cfg),
    .track_nr_x3(track_nr_x3), .track_active(track_active), .corner_khz(corner_khz),
    .tr_x3(tr_x3), .tp_val(tp_val), .env_coef_valid(env_coef_valid),
    .batt_save(batt_save), .irq(irq));

  // ---------------------------------------------------------------
  // clock, reference tick and cycle count
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    cyc = 0;
    forever #4 pclk = ~pclk;
  end
  // reference period elapses every second cycle
  always @(posedge pclk) begin
    ref_tick <= ~ref_tick;
    cyc      <= cyc + 1;
  end

  // ---------------------------------------------------------------
  // checking and expectation helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // three times a time constant: odd codes sit at two thirds of the next step
  function automatic logic [15:0] tc3(input logic [2:0] c, input int base);
    return 16'((c[0] ? 4 : 3) * (base << c[2:1]));
  endfunction : tc3
  function automatic logic [15:0] corner(input logic [1:0] c);
    case (c)
      2'h0: return 16'h0277;
      2'h1: return 16'h0293;
      2'h2: return 16'h02B1;
      default: return 16'h02C8;
    endcase
  endfunction : corner

  // ---------------------------------------------------------------
  // apb transfers and run control
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      test_done();
    end
    rdat = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    xfer(1'b0, idx, 32'h00000000);
  endtask : rd
  // leave saving for run; counting starts at the request
  task automatic wake();
    wake_req <= 1'b0;
    repeat (4) @(posedge pclk);
    wake_req <= 1'b1;
    t0 = cyc;
    repeat (3) @(posedge pclk);
  endtask : wake
  // run until shut-off, optionally rewriting the duration while running
  task automatic run_off(input int n, input int late);
    int k;
    int lim;
    k = (n == 0 ? 255 : n - 1) * 8;
    wake();
    if (late >= 0) wr(`RCEM_IDX_SHUTOFF, 32'(late));
    lim = 0;
    while (batt_save !== 1'b1 && lim < 3000) begin
      @(posedge pclk);
      lim++;
    end
    chk_rng("shutoff cycles", k - 4, k + 12, cyc - t0);
  endtask : run_off

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ref_tick, wake_req, nvm_mode} = '0;
    {qc1_settled, qc2_below_th, det_pins, envelope_in, drift_in, average_in} = '0;
    {clk_en, digital_en, presetn} = 3'h6;
    void'($urandom(32'h61F3C211));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RCEM_IDX_CMP_SET);
    chk("cmp reset", 16'h0060, rdat[15:0]);
    rd(`RCEM_IDX_ENV_SET);
    chk("env reset", 16'h0088, rdat[15:0]);
    rd(`RCEM_IDX_SHUTOFF);
    chk("shutoff reset", 16'h0000, rdat[15:0]);
    // every coefficient code, random spare bits
    for (int c = 0; c < 8; c++) begin
      v = 8'($urandom);
      v[5:1] = {3'(c), 2'(c)};
      wr(`RCEM_IDX_CMP_SET, {24'h000000, v});
      rd(`RCEM_IDX_CMP_SET);
      chk("cmp reg", 16'(v), rdat[15:0]);
      chk("track nr", tc3(3'(c), 128), 16'(track_nr_x3));
      chk("corner", corner(2'(c)), 16'(corner_khz));
      v[7:3] = {3'(c), 2'(c)};
      wr(`RCEM_IDX_ENV_SET, {24'h000000, v});
      @(posedge pclk);
      chk("tr", tc3(3'(c), 64), 16'(tr_x3));
      chk("tp", 16'(8 << c[1:0]), 16'(tp_val));
    end
    // interference filter on: trims for delay, then pulse-count detection
    wr(`RCEM_IDX_CTRL, 32'h00000008);
    wr(`RCEM_IDX_CMP_SET, 32'h00000001);
    for (int p = 0; p < 2; p++) begin
      wr(`RCEM_IDX_ENV_SET, p ? 32'h00000004 : 32'h00000002);
      @(posedge pclk);
      chk("trims", p ? 16'h000C : 16'h000A, 16'({cmp_cfg.trim_a, env_cfg.trim_b,
          env_cfg.trim_c, env_cfg.trim_d}));
    end
    // tracking and envelope field enables over all conditions
    for (int k = 0; k < 16; k++) begin
      qc1_settled  <= k[2];
      qc2_below_th <= k[3];
      wr(`RCEM_IDX_CTRL, 32'({k[1], k[0], 1'b0}));
      @(posedge pclk);
      chk("track active", 16'(!k[0] | k[2] | k[3]), 16'(track_active));
      chk("env valid", 16'(k[1] & k[0]), 16'(env_coef_valid));
    end
    // status and monitor values, over-range drift and disabled block among them
    for (int i = 0; i < 8; i++) begin
      det_pins    <= rcem_detect_t'(4'($urandom));
      envelope_in <= 8'($urandom);
      average_in  <= 8'($urandom);
      drift_in    <= (i == 0) ? 9'h112 : 9'($urandom);
      digital_en  <= (i % 3 != 1);
      wr(`RCEM_IDX_CTRL, 32'({i[0], 2'b00}));
      repeat (3) @(posedge pclk);
      rd(`RCEM_IDX_STATUS);
      chk("status", {8'h00, det_pins, 4'h0}, rdat[15:0]);
      wr(`RCEM_IDX_ENV_MON, 32'($urandom));
      rd(`RCEM_IDX_ENV_MON);
      chk("envelope", i[0] ? 16'(envelope_in) : 16'h0000, rdat[15:0]);
      rd(`RCEM_IDX_DRIFT_MON);
      v = !digital_en ? 8'h00 : drift_in[8] ? 8'hFF : drift_in[7:0];
      chk("drift", 16'(v), rdat[15:0]);
      rd(`RCEM_IDX_AVG_MON);
      chk("average", digital_en ? 16'(average_in) : 16'h0000, rdat[15:0]);
    end
    rd(8'h05);
    chk("unmapped err", 16'h0001, 16'(err));
    chk("unmapped data", 16'h0000, rdat[15:0]);
    wr(`RCEM_IDX_SHUTOFF, 32'h00000055);
    rd(`RCEM_IDX_SHUTOFF);
    chk("duration", 16'h0055, rdat[15:0]);
    nvm_mode <= 1'b1;
    wr(`RCEM_IDX_SHUTOFF, 32'h000000AA);
    rd(`RCEM_IDX_SHUTOFF);
    chk("nvm duration", 16'h0000, rdat[15:0]);
    nvm_mode <= 1'b0;
    // clock enable low freezes the bank
    clk_en <= 1'b0;
    wr(`RCEM_IDX_SHUTOFF, 32'h00000044);
    clk_en <= 1'b1;
    rd(`RCEM_IDX_SHUTOFF);
    chk("frozen write", 16'h0000, rdat[15:0]);
    // shut-off timer, duration rewritten while running
    det_pins <= rcem_detect_t'(4'h0);
    wr(`RCEM_IDX_SHUTOFF, 32'h00000003);
    wr(`RCEM_IDX_CTRL, 32'h00000001);
    run_off(3, 6);
    rd(`RCEM_IDX_IRQ_STAT);
    chk("irq status", 16'h0001, 16'(rdat[0]));
    wr(`RCEM_IDX_IRQ_MASK, 32'h00000000);
    @(posedge pclk);
    irq_a = irq;
    wr(`RCEM_IDX_IRQ_MASK, 32'h00000007);
    @(posedge pclk);
    chk("irq mask", 16'h0001, 16'(irq_a ^ irq));
    wr(`RCEM_IDX_IRQ_STAT, 32'h00000007);
    @(posedge pclk);
    chk("irq clear", 16'h0000, 16'(irq));
    run_off(6, -1);
    wr(`RCEM_IDX_SHUTOFF, 32'h00000001);
    run_off(1, -1);
    wr(`RCEM_IDX_SHUTOFF, 32'h00000000);
    run_off(0, -1);
    // no shut-off when type B is off, or when a detection is present
    wr(`RCEM_IDX_SHUTOFF, 32'h00000003);
    for (int j = 0; j < 2; j++) begin
      wr(`RCEM_IDX_CTRL, 32'(j));
      det_pins <= rcem_detect_t'(j ? 4'h4 : 4'h0);
      wake();
      repeat (60) @(posedge pclk);
      chk("no shutoff", 16'h0000, 16'(batt_save));
    end
    test_done();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    test_done();
  end
endmodule : rcem_regs_tb
